// [lin_mode_pkg.sv]
// constants shared by the lin transceiver mode controller and its time base
// assumes a 40 MHz system clock; all timing counts are time-base ticks
package lin_mode_pkg;

  // system clock period and time-base tick
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_DIV = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // recessive clear time is a longest time, so the tick count rounds down
  localparam int TX_RECESSIVE_CLEAR_TIME_NS = 10000;
  localparam int TX_RECESSIVE_CLEAR_TICKS = (TX_RECESSIVE_CLEAR_TIME_NS / TICK_NS < 1) ? 1 :
                                            TX_RECESSIVE_CLEAR_TIME_NS / TICK_NS;

  // default tick counts for the timers whose values are not given
  localparam int INIT_GUARD_TICKS = 200;
  localparam int TX_DOMINANT_TICKS = 100;
  localparam int RESET_HOLD_TICKS = 50;
  localparam int CNT_W = 16;

  // positions of the synchronised pin inputs
  localparam int IN_MODE = 0;
  localparam int IN_TX = 1;
  localparam int IN_BUS = 2;
  localparam int IN_WAKE = 3;
  localparam int IN_SUPPLY = 4;
  localparam int IN_OTREC = 5;
  localparam int N_IN = 6;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_INIT = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_STANDBY = 4'h4,
    MODE_SLEEP = 4'h8
  } mode_t;

endpackage

// [tick_divider.sv]
// time-base divider: one-cycle tick enable every div_count clocks
// assumes a free-running clk and a synchronous active-high reset
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV_COUNT = 40,
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // time-base enable
  output logic tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } div_t;

  div_t q;
  div_t d;

  // count down and pulse at the wrap
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == '0) begin
      d.cnt = DIV_W'(DIV_COUNT - 1);
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // tick pulses never come two in a row when dividing
  property p_tick_single;
    q.tick && (DIV_COUNT > 1) |=> !q.tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick held longer than one cycle");

endmodule

// [lin_mode_ctrl.sv]
// mode controller of a lin transceiver with built-in supply regulator
// assumes pins arrive asynchronously; supply_ok, bus_wake, bus_dominant and
// overtemp_recovered come from analogue comparators and filters outside
`timescale 1ns/10ps
module lin_mode_ctrl
  import lin_mode_pkg::*;
#(
  parameter int INIT_GUARD_TIME = INIT_GUARD_TICKS,
  parameter int TX_DOMINANT_LIMIT = TX_DOMINANT_TICKS,
  parameter int TX_RECESSIVE_CLEAR = TX_RECESSIVE_CLEAR_TICKS,
  parameter int RESET_HOLD_TIME = RESET_HOLD_TICKS,
  parameter int TICK_CYCLES = TICK_DIV
) (
  // clock and reset; reset stands for a power-up of the device
  input wire logic clk,
  input wire logic srst,
  // host pins
  input wire logic mode_request,
  input wire logic tx_in,
  output logic rx_out,
  output logic mcu_reset_release,
  // bus side
  input wire logic bus_dominant,
  input wire logic bus_wake,
  output logic bus_drive_dominant,
  output logic tx_enable,
  // regulator status
  input wire logic supply_ok,
  input wire logic overtemp_recovered,
  // status
  output mode_t mode,
  output logic tx_dominant_fail
);

  typedef struct packed {
    logic [N_IN-1:0] s1;
    logic [N_IN-1:0] s2;
    logic [N_IN-1:0] s3;
    mode_t mode;
    logic [CNT_W-1:0] guard_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] dom_cnt;
    logic [CNT_W-1:0] rec_cnt;
    logic hold_done;
    logic wake_seen;
    logic tx_fail;
    logic rx;
    logic release_o;
    logic drive;
    logic tx_en;
  } state_t;

  localparam logic [CNT_W-1:0] GUARD_LAST = CNT_W'(INIT_GUARD_TIME - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RESET_HOLD_TIME - 1);
  localparam logic [CNT_W-1:0] DOM_LIMIT = CNT_W'(TX_DOMINANT_LIMIT);
  localparam logic [CNT_W-1:0] REC_LIMIT = CNT_W'(TX_RECESSIVE_CLEAR);

  state_t q;
  state_t d;
  logic tick;
  logic mr;
  logic tx;
  logic sup;
  logic wake;
  logic mr_rise;
  logic mr_fall;
  logic sup_fall;
  logic ot_rise;

  // time base
  tick_divider #(
    .DIV_COUNT(TICK_CYCLES),
    .DIV_W(CNT_W)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(tick)
  );

  // synchronised levels and their edges; stage s1 feeds only s2
  assign mr = q.s2[IN_MODE];
  assign tx = q.s2[IN_TX];
  assign sup = q.s2[IN_SUPPLY];
  assign wake = q.s2[IN_WAKE];
  assign mr_rise = q.s2[IN_MODE] && !q.s3[IN_MODE];
  assign mr_fall = !q.s2[IN_MODE] && q.s3[IN_MODE];
  assign sup_fall = !q.s2[IN_SUPPLY] && q.s3[IN_SUPPLY];
  assign ot_rise = q.s2[IN_OTREC] && !q.s3[IN_OTREC];

  // next-state logic for the whole controller
  always_comb begin
    d = q;
    d.s1 = {overtemp_recovered, supply_ok, bus_wake, bus_dominant, tx_in, mode_request};
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (!sup) begin
      d.hold_cnt = '0;
      d.hold_done = 1'b0;
    end else if (tick && !q.hold_done) begin
      d.hold_cnt = q.hold_cnt + 1'b1;
      d.hold_done = (q.hold_cnt == HOLD_LAST);
    end
    case (q.mode)
      MODE_INIT: begin
        // stops once supply and request are good
        if (tick && !(sup && mr)) begin
          d.guard_cnt = q.guard_cnt + 1'b1;
        end
        if (sup_fall) begin
          d.guard_cnt = '0;
        end
        if (q.hold_done && mr) begin
          d.mode = MODE_NORMAL;
          d.wake_seen = 1'b0;
        end else if (tick && !(sup && mr) && q.guard_cnt == GUARD_LAST && !sup_fall) begin
          d.mode = MODE_SLEEP;
          d.wake_seen = 1'b0;
        end
      end
      MODE_NORMAL: begin
        if (sup_fall || ot_rise) begin
          d.mode = MODE_INIT;
        end else if (mr_fall) begin
          d.mode = tx ? MODE_STANDBY : MODE_SLEEP;
        end
        if (!tx) begin
          d.rec_cnt = '0;
          if (tick && q.dom_cnt != DOM_LIMIT) begin
            d.dom_cnt = q.dom_cnt + 1'b1;
          end
          if (q.dom_cnt == DOM_LIMIT) begin
            d.tx_fail = 1'b1;
          end
        end else begin
          if (tick && q.rec_cnt != REC_LIMIT) begin
            d.rec_cnt = q.rec_cnt + 1'b1;
          end
          if (q.rec_cnt == REC_LIMIT) begin
            d.dom_cnt = '0;
            d.tx_fail = 1'b0;
          end
        end
      end
      MODE_STANDBY: begin
        if (wake) begin
          d.mode = MODE_INIT;
          d.wake_seen = 1'b1;
        end else if (sup_fall || ot_rise) begin
          d.mode = MODE_INIT;
        end else if (mr_rise) begin
          d.mode = MODE_NORMAL;
        end
      end
      MODE_SLEEP: begin
        if (wake) begin
          d.mode = MODE_INIT;
          d.wake_seen = 1'b1;
        end else if (mr_rise) begin
          // only an edge wakes, a standing level does not
          d.mode = MODE_INIT;
        end
      end
      default: begin
        d.mode = MODE_INIT;
      end
    endcase
    if (d.mode == MODE_INIT && q.mode != MODE_INIT) begin
      d.guard_cnt = '0;
    end
    if (d.mode != MODE_INIT) begin
      d.guard_cnt = '0;
    end
    if (d.mode != MODE_NORMAL) begin
      d.dom_cnt = '0;
      d.rec_cnt = '0;
      d.tx_fail = 1'b0;
    end
    d.tx_en = (d.mode == MODE_NORMAL) && !d.tx_fail;
    d.drive = d.tx_en && !tx;
    case (d.mode)
      MODE_NORMAL: d.rx = !q.s2[IN_BUS];
      MODE_INIT: d.rx = !d.wake_seen;
      default: d.rx = 1'b1;
    endcase
    // release needs hold and no sleep
    d.release_o = d.hold_done && (d.mode != MODE_SLEEP);
  end

  // state register; a power-up lands in init with the guard at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.mode <= MODE_INIT;
      q.rx <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rx_out = q.rx;
  assign mcu_reset_release = q.release_o;
  assign bus_drive_dominant = q.drive;
  assign tx_enable = q.tx_en;
  assign mode = q.mode;
  assign tx_dominant_fail = q.tx_fail;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_standby_edge;
    q.mode == MODE_STANDBY && mr_rise && !wake && !sup_fall && !ot_rise;
  endsequence
  // entry itself carries the enabled transmitter; a later exit must not count against it
  sequence s_enter_normal;
    q.mode == MODE_NORMAL && q.tx_en && !q.tx_fail;
  endsequence

  property p_standby_to_normal;
    s_standby_edge |=> s_enter_normal;
  endproperty
  a_standby_to_normal: assert property (p_standby_to_normal) else $error("stand-by edge did not reach normal");

  property p_drive_only_normal;
    q.drive |-> q.mode == MODE_NORMAL && q.tx_en && !q.tx_fail;
  endproperty
  a_drive_only_normal: assert property (p_drive_only_normal) else $error("bus driven outside normal");

  property p_guard_idle;
    q.mode != MODE_INIT |-> q.guard_cnt == '0;
  endproperty
  a_guard_idle: assert property (p_guard_idle) else $error("guard timer running outside init");

  property p_guard_restart;
    q.mode != MODE_INIT ##1 q.mode == MODE_INIT |-> q.guard_cnt == '0;
  endproperty
  a_guard_restart: assert property (p_guard_restart) else $error("guard not restarted on init entry");

  property p_normal_fall;
    q.mode == MODE_NORMAL && mr_fall && !sup_fall && !ot_rise |=>
      q.mode == ($past(tx) ? MODE_STANDBY : MODE_SLEEP);
  endproperty
  a_normal_fall: assert property (p_normal_fall) else $error("wrong mode after request fell");

  property p_sleep_holds;
    q.mode == MODE_SLEEP && !mr_rise && !wake |=> q.mode == MODE_SLEEP;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("left sleep without an edge or wake");

  property p_sleep_release_low;
    q.mode == MODE_SLEEP |-> !mcu_reset_release;
  endproperty
  a_sleep_release_low: assert property (p_sleep_release_low) else $error("release high in sleep");

  property p_dom_idle;
    q.mode != MODE_NORMAL |-> q.dom_cnt == '0 && !q.tx_fail;
  endproperty
  a_dom_idle: assert property (p_dom_idle) else $error("dominant check active outside normal");

  property p_fail_frees_bus;
    q.tx_fail |-> !q.drive && !q.tx_en;
  endproperty
  a_fail_frees_bus: assert property (p_fail_frees_bus) else $error("transmitter on after dominant failure");

  property p_standby_rx;
    q.mode == MODE_STANDBY |-> rx_out;
  endproperty
  a_standby_rx: assert property (p_standby_rx) else $error("rx low in stand-by without wake");

  // release is registered, so it follows the supply level of the cycle before
  property p_release_needs_hold;
    mcu_reset_release |-> q.hold_done && $past(sup);
  endproperty
  a_release_needs_hold: assert property (p_release_needs_hold) else $error("release without hold time");

  property p_wake_to_init;
    (q.mode == MODE_SLEEP || q.mode == MODE_STANDBY) && wake |=> q.mode == MODE_INIT;
  endproperty
  a_wake_to_init: assert property (p_wake_to_init) else $error("wake did not enter init");

endmodule

// [lin_host_model.sv]
// host microcontroller model: drives mode_request and tx_in
// assumes bench wishes are levels on clk; pins move just after a rising edge
`timescale 1ns/10ps
module lin_host_model #(
  parameter int MAX_DOM = 16
) (
  // clock, reset and supply seen by the host
  input wire logic clk,
  input wire logic srst,
  input wire logic supply_ok,
  // wishes of the bench
  input wire logic want_req,
  input wire logic want_tx,
  input wire logic allow_long,
  // pins towards the controller
  output logic mode_request,
  output logic tx_in
);
  logic [7:0] dom_q;

  // pins registered so the controller sees clean edge-aligned levels
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_request <= 1'b0;
      tx_in <= 1'b1;
      dom_q <= 8'h00;
    end else begin
      // raise request only on good supply
      mode_request <= want_req & (supply_ok | mode_request);
      // dominant runs capped, held recessive until released
      if (want_tx) begin
        tx_in <= 1'b1;
        dom_q <= 8'h00;
      end else if (allow_long || dom_q < MAX_DOM) begin
        tx_in <= 1'b0;
        dom_q <= dom_q + 8'h01;
      end else begin
        tx_in <= 1'b1;
      end
    end
  end
endmodule

// [test_lin_mode_ctrl.sv]
// testbench of the lin mode controller with a host model on the pin side
// assumes shortened timers; the bus wire is the driver output looped back
`timescale 1ns/10ps
module test_lin_mode_ctrl import lin_mode_pkg::*; ;
  logic clk = 1'b0, srst = 1'b1, supply_ok = 1'b1, bus_wake = 1'b0, otrec = 1'b0;
  logic want_req = 1'b0, want_tx = 1'b1, allow_long = 1'b0;
  logic mode_request, tx_in, rx_out, rel, drive, tx_en, fail;
  mode_t mode, prev;
  mode_t exp_q[$];
  int errors = 0, checked = 0, cyc = 0, i;
  integer seed = 32'h3DE45D74;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  lin_mode_ctrl #(.INIT_GUARD_TIME(20), .TX_DOMINANT_LIMIT(10), .TX_RECESSIVE_CLEAR(3),
    .RESET_HOLD_TIME(5), .TICK_CYCLES(2)) lin_mode_ctrl_i (.clk(clk), .srst(srst),
    .mode_request(mode_request), .tx_in(tx_in), .rx_out(rx_out), .mcu_reset_release(rel),
    .bus_dominant(drive), .bus_wake(bus_wake), .bus_drive_dominant(drive), .tx_enable(tx_en),
    .supply_ok(supply_ok), .overtemp_recovered(otrec), .mode(mode), .tx_dominant_fail(fail));
  lin_host_model lin_host_model_i (.clk(clk), .srst(srst), .supply_ok(supply_ok),
    .want_req(want_req), .want_tx(want_tx), .allow_long(allow_long),
    .mode_request(mode_request), .tx_in(tx_in));

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // note the next mode, then wait for it under a bound
  task automatic step(input mode_t m, input int lim);
    exp_q.push_back(m);
    for (i = 0; i < lim && mode !== m; i++) tk(1);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watcher: every mode change takes the oldest note; stray changes are errors
  always @(posedge clk) begin
    if (!srst && mode !== prev) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] mode expected none seen %h", mode);
      end else
        check("mode", mode, exp_q.pop_front());
    end
    prev <= mode;
  end

  // cycle ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] run_cycles expected below 20000 seen %0d", cyc);
      conclude();
    end
  end

  initial begin
    tk(6);
    srst <= 1'b0;
    tk(2);
    check("release", rel, 1'b0);
    check("tx_enable", tx_en, 1'b0);
    tk(6);
    check("release", rel, 1'b0);
    for (i = 0; i < 40 && rel !== 1'b1; i++) tk(1);
    check("release", rel, 1'b1);
    step(MODE_SLEEP, 100);
    check("release", rel, 1'b0);
    $display("test power_up_request_low done");
    want_req <= 1'b1;
    step(MODE_INIT, 20);
    step(MODE_NORMAL, 100);
    check("release", rel, 1'b1);
    check("tx_enable", tx_en, 1'b1);
    // random transmit bits, each followed by a recessive gap
    repeat (8) begin
      want_tx <= 1'($random(seed));
      tk(8);
      check("bus_drive", drive, !tx_in);
      check("rx_out", rx_out, tx_in);
      want_tx <= 1'b1;
      tk(8);
    end
    $display("test normal_echo done");
    // a recessive gap longer than the clear time restarts the dominant count
    want_tx <= 1'b0;
    tk(14);
    want_tx <= 1'b1;
    tk(10);
    want_tx <= 1'b0;
    tk(14);
    check("dom_fail", fail, 1'b0);
    allow_long <= 1'b1;
    for (i = 0; i < 40 && fail !== 1'b1; i++) tk(1);
    tk(2);
    check("dom_fail", fail, 1'b1);
    check("tx_enable", tx_en, 1'b0);
    check("bus_drive", drive, 1'b0);
    want_tx <= 1'b1;
    allow_long <= 1'b0;
    for (i = 0; i < 30 && fail !== 1'b0; i++) tk(1);
    tk(2);
    check("dom_fail", fail, 1'b0);
    check("tx_enable", tx_en, 1'b1);
    $display("test dominant_timeout done");
    want_req <= 1'b0;
    step(MODE_STANDBY, 20);
    check("release", rel, 1'b1);
    check("rx_out", rx_out, 1'b1);
    want_req <= 1'b1;
    step(MODE_NORMAL, 20);
    // overtemperature recovery in normal drops through init and back
    otrec <= 1'b1;
    step(MODE_INIT, 20);
    otrec <= 1'b0;
    step(MODE_NORMAL, 20);
    check("release", rel, 1'b1);
    want_req <= 1'b0;
    step(MODE_STANDBY, 20);
    bus_wake <= 1'b1;
    step(MODE_INIT, 20);
    tk(1);
    check("rx_out", rx_out, 1'b0);
    bus_wake <= 1'b0;
    step(MODE_SLEEP, 100);
    $display("test standby_wake done");
    tk(4);
    bus_wake <= 1'b1;
    step(MODE_INIT, 20);
    bus_wake <= 1'b0;
    for (i = 0; i < 40 && rel !== 1'b1; i++) tk(1);
    check("release", rel, 1'b1);
    step(MODE_SLEEP, 100);
    check("release", rel, 1'b0);
    $display("test sleep_wake_low done");
    want_req <= 1'b1;
    step(MODE_INIT, 20);
    step(MODE_NORMAL, 100);
    supply_ok <= 1'b0;
    step(MODE_INIT, 20);
    tk(1);
    check("release", rel, 1'b0);
    step(MODE_SLEEP, 100);
    check("guard_len", {3'h0, i >= 36 && i <= 46}, 4'h1);
    supply_ok <= 1'b1;
    tk(60);
    check("mode", mode, MODE_SLEEP);
    bus_wake <= 1'b1;
    step(MODE_INIT, 20);
    bus_wake <= 1'b0;
    step(MODE_NORMAL, 100);
    check("release", rel, 1'b1);
    $display("test undervoltage_and_wake done");
    want_req <= 1'b0;
    want_tx <= 1'b0;
    step(MODE_SLEEP, 20);
    check("release", rel, 1'b0);
    want_tx <= 1'b1;
    tk(5);
    check("notes_left", 4'(exp_q.size()), 4'h0);
    $display("test normal_to_sleep done");
    conclude();
  end
endmodule
